// ===== hola_alarm.v
/*
  Heater overcurrent monitor and control loop break monitor for one
  channel, with an APB register slave. Currents are in tenths of an
  ampere; process value and set point arrive as signed counts at the
  sensor decimal position. Assumes all inputs are synchronous to REF_CLK.
*/
`timescale 1ns/1ps
`include "hola_defines.vh"

module hola_alarm #(
  parameter ON_MIN_CYCLES = `HOLA_ON_MIN_MS * (`HOLA_CLK_HZ / 1000),
  parameter SEC_CYCLES    = `HOLA_SEC_S * `HOLA_CLK_HZ
) (
  input  wire        REF_CLK,
  input  wire        RSTN,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire        SW_RESET,
  input  wire        RUNNING,
  input  wire        SP_RAMPING,
  input  wire        AUTOTUNING,
  input  wire        MANUAL_MODE,
  input  wire        HEAT_ON,
  input  wire        COOLING_OUTPUT,
  input  wire        CURRENT_TRANSFORMER_INPUT,
  input  wire [10:0] HEATER_CURRENT,
  input  wire [1:0]  DECIMAL_POS,
  input  wire signed [15:0] PROCESS_VALUE,
  input  wire signed [15:0] SET_POINT,
  output reg         HEATER_OVERCURRENT_ALARM,
  output reg         LOOP_BREAK_ALARM
);

  reg  [10:0] oc_thr_reg;
  reg  [10:0] hyst_pend_reg;
  reg  [10:0] hyst_act_reg;
  reg         oc_latch_reg;
  reg  [13:0] lb_time_reg;
  reg  [13:0] lb_level_reg;
  reg  [13:0] lb_band_reg;
  reg  [7:0]  alm_type_reg;
  reg  [10:0] ct_mon_reg;
  reg  [21:0] on_cnt_reg;
  reg  [24:0] sec_cnt_reg;
  reg  [13:0] intv_reg;
  reg  [17:0] ref_dev_reg;

  reg  [31:0] rdata_next;
  wire        wr_en = PSEL & PENABLE & PWRITE;
  wire        locked_off;
  reg         mapped;
  reg         err;
  wire [10:0] wdata11 = PWDATA[10:0];
  wire [13:0] wdata14 = PWDATA[13:0];

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & err;

  assign locked_off = (PADDR == `HOLA_OFF_OC_HYST) || (PADDR == `HOLA_OFF_OC_LATCH) ||
                      (PADDR == `HOLA_OFF_LB_TIME) || (PADDR == `HOLA_OFF_LB_LEVEL) ||
                      (PADDR == `HOLA_OFF_LB_BAND);

  // Decode and error answer; a refused write stores nothing.
  always @* begin
    case (PADDR)
      `HOLA_OFF_OC_THR, `HOLA_OFF_OC_HYST, `HOLA_OFF_OC_LATCH, `HOLA_OFF_LB_TIME,
      `HOLA_OFF_LB_LEVEL, `HOLA_OFF_LB_BAND, `HOLA_OFF_ALM_TYPE, `HOLA_OFF_CT_MON,
      `HOLA_OFF_STATUS, `HOLA_OFF_COMMAND: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    err = ~mapped | (PWRITE & RUNNING & locked_off);
  end

  wire do_wr = wr_en & ~err;
  wire thr_wr = do_wr && (PADDR == `HOLA_OFF_OC_THR);
  wire rst_err_cmd = do_wr && (PADDR == `HOLA_OFF_COMMAND) && PWDATA[`HOLA_CMD_RST_ERR];

  always @* begin
    rdata_next = 32'h00000000;
    case (PADDR)
      `HOLA_OFF_OC_THR:   rdata_next[10:0] = oc_thr_reg;
      `HOLA_OFF_OC_HYST:  rdata_next[10:0] = hyst_pend_reg;
      `HOLA_OFF_OC_LATCH: rdata_next[0]    = oc_latch_reg;
      `HOLA_OFF_LB_TIME:  rdata_next[13:0] = lb_time_reg;
      `HOLA_OFF_LB_LEVEL: rdata_next[13:0] = lb_level_reg;
      `HOLA_OFF_LB_BAND:  rdata_next[13:0] = lb_band_reg;
      `HOLA_OFF_ALM_TYPE: rdata_next[7:0]  = alm_type_reg;
      `HOLA_OFF_CT_MON:   rdata_next[10:0] = ct_mon_reg;
      `HOLA_OFF_STATUS: begin
        rdata_next[`HOLA_ST_OC_BIT] = HEATER_OVERCURRENT_ALARM;
        rdata_next[`HOLA_ST_LB_BIT] = LOOP_BREAK_ALARM;
      end
      default: rdata_next = 32'h00000000;
    endcase
  end

  // Read data is captured in the setup cycle so that it comes from a flop
  // without a wait state; the value shown is that of one cycle earlier.
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN)
      PRDATA <= 32'h00000000;
    else if (PSEL && !PENABLE)
      PRDATA <= rdata_next;
  end

  // Out-of-range settings are clamped to the top of their range; a zero hysteresis or loop break level is stored as 1.
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      oc_thr_reg    <= `HOLA_RST_OC_THR;
      hyst_pend_reg <= `HOLA_RST_OC_HYST;
      oc_latch_reg  <= 1'b0;
      lb_time_reg   <= `HOLA_RST_LB_TIME;
      lb_level_reg  <= `HOLA_RST_LB_LEVEL;
      lb_band_reg   <= `HOLA_RST_LB_BAND;
      alm_type_reg  <= `HOLA_RST_ALM_TYPE;
    end else if (do_wr) begin
      case (PADDR)
        `HOLA_OFF_OC_THR:
          oc_thr_reg <= (wdata11 > `HOLA_OC_THR_MAX) ? `HOLA_OC_THR_MAX : wdata11;
        `HOLA_OFF_OC_HYST:
          hyst_pend_reg <= (wdata11 > `HOLA_HYST_MAX) ? `HOLA_HYST_MAX :
                           (wdata11 == 11'h000) ? 11'h001 : wdata11;
        `HOLA_OFF_OC_LATCH: oc_latch_reg <= PWDATA[0];
        `HOLA_OFF_LB_TIME:
          lb_time_reg <= (wdata14 > `HOLA_LB_TIME_MAX) ? `HOLA_LB_TIME_MAX : wdata14;
        `HOLA_OFF_LB_LEVEL:
          lb_level_reg <= (wdata14 > `HOLA_LB_VAL_MAX) ? `HOLA_LB_VAL_MAX :
                          (wdata14 == 14'h0000) ? 14'h0001 : wdata14;
        `HOLA_OFF_LB_BAND:
          lb_band_reg <= (wdata14 > `HOLA_LB_VAL_MAX) ? `HOLA_LB_VAL_MAX : wdata14;
        `HOLA_OFF_ALM_TYPE: alm_type_reg <= PWDATA[7:0];
        default: oc_thr_reg <= oc_thr_reg;
      endcase
    end
  end

  // The working hysteresis only moves on a unit software reset or power-up,
  // so a value staged while stopped cannot disturb a running comparison.
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN)
      hyst_act_reg <= `HOLA_RST_OC_HYST;
    else if (SW_RESET)
      hyst_act_reg <= hyst_pend_reg;
  end

  // Heating on-time: detection opens only once the pulse outlasts 100 ms.
  wire on_valid = (on_cnt_reg > ON_MIN_CYCLES);
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN)
      on_cnt_reg <= 22'h000000;
    else if (!HEAT_ON)
      on_cnt_reg <= 22'h000000;
    else if (!on_valid)
      on_cnt_reg <= on_cnt_reg + 22'h000001;
  end

  wire oc_avail = CURRENT_TRANSFORMER_INPUT & ~COOLING_OUTPUT;
  wire [10:0] clr_lvl = (oc_thr_reg > hyst_act_reg) ? (oc_thr_reg - hyst_act_reg)
                                                    : 11'h000;
  reg oc_next;

  always @* begin
    oc_next = HEATER_OVERCURRENT_ALARM;
    if (!oc_avail)
      oc_next = 1'b0;
    else if (oc_thr_reg == `HOLA_OC_FORCE_OFF)
      oc_next = 1'b0;
    else if (oc_thr_reg == `HOLA_OC_FORCE_ON)
      oc_next = 1'b1;
    else if (HEAT_ON && on_valid) begin
      if (HEATER_CURRENT > oc_thr_reg)
        oc_next = 1'b1;
      else if (HEATER_CURRENT < clr_lvl && !oc_latch_reg)
        oc_next = 1'b0;
    end
    if (HEATER_OVERCURRENT_ALARM && oc_latch_reg && oc_avail &&
        oc_thr_reg != `HOLA_OC_FORCE_OFF)
      oc_next = 1'b1;
    if (rst_err_cmd || SW_RESET || (thr_wr && wdata11 >= `HOLA_OC_FORCE_OFF))
      oc_next = 1'b0;
  end

  // The alarm is a plain output; nothing here gates the heating output.
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      HEATER_OVERCURRENT_ALARM <= 1'b0;
      ct_mon_reg               <= 11'h000;
    end else begin
      HEATER_OVERCURRENT_ALARM <= oc_next;
      ct_mon_reg               <= HEATER_CURRENT;
    end
  end

  // With decimal position 0 the inputs are whole units, scaled by ten so
  // they share the tenths resolution of the level and band settings.
  wire signed [17:0] pv_s = {{2{PROCESS_VALUE[15]}}, PROCESS_VALUE};
  wire signed [17:0] sp_s = {{2{SET_POINT[15]}}, SET_POINT};
  wire signed [17:0] raw_dev = sp_s - pv_s;
  wire signed [17:0] dev_sc = (DECIMAL_POS == 2'b00) ?
                              ((raw_dev <<< 3) + (raw_dev <<< 1)) : raw_dev;
  wire [17:0] dev_abs = dev_sc[17] ? (18'h00000 - dev_sc) : dev_sc;
  wire signed [18:0] reduce = $signed({1'b0, ref_dev_reg}) - $signed({1'b0, dev_abs});
  wire band_met = (reduce >= $signed({5'h00, lb_band_reg}));

  wire lb_en = (alm_type_reg == `HOLA_ALM_TYPE_LB) && (lb_time_reg != 14'h0000) &&
               RUNNING && !SP_RAMPING && !AUTOTUNING && !MANUAL_MODE;
  wire outside = (dev_abs > {4'h0, lb_level_reg});
  wire sec_tick = (sec_cnt_reg == SEC_CYCLES - 1);
  wire intv_end = sec_tick && (intv_reg + 14'h0001 >= lb_time_reg);

  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      LOOP_BREAK_ALARM <= 1'b0;
      sec_cnt_reg      <= 25'h0000000;
      intv_reg         <= 14'h0000;
      ref_dev_reg      <= 18'h00000;
    end else if (!lb_en || !outside) begin
      LOOP_BREAK_ALARM <= 1'b0;
      sec_cnt_reg      <= 25'h0000000;
      intv_reg         <= 14'h0000;
      ref_dev_reg      <= dev_abs;
    end else if (LOOP_BREAK_ALARM && band_met) begin
      LOOP_BREAK_ALARM <= 1'b0;
      sec_cnt_reg      <= 25'h0000000;
      intv_reg         <= 14'h0000;
      ref_dev_reg      <= dev_abs;
    end else if (intv_end) begin
      LOOP_BREAK_ALARM <= ~band_met;
      sec_cnt_reg      <= 25'h0000000;
      intv_reg         <= 14'h0000;
      ref_dev_reg      <= dev_abs;
    end else begin
      sec_cnt_reg <= sec_tick ? 25'h0000000 : sec_cnt_reg + 25'h0000001;
      if (sec_tick)
        intv_reg <= intv_reg + 14'h0001;
    end
  end

endmodule

// ===== hola_defines.vh
/*
  Constants for the heater overcurrent and loop break alarm block:
  register byte offsets, reset values, field codes and timing figures.
  Assumes it is included by its bare name and holds definitions only.
*/
`ifndef HOLA_DEFINES_VH
`define HOLA_DEFINES_VH

`define HOLA_CLK_HZ        25000000
`define HOLA_ON_MIN_MS     100
`define HOLA_SEC_S         1

`define HOLA_OFF_OC_THR    8'h00
`define HOLA_OFF_OC_HYST   8'h04
`define HOLA_OFF_OC_LATCH  8'h08
`define HOLA_OFF_LB_TIME   8'h0C
`define HOLA_OFF_LB_LEVEL  8'h10
`define HOLA_OFF_LB_BAND   8'h14
`define HOLA_OFF_ALM_TYPE  8'h18
`define HOLA_OFF_CT_MON    8'h1C
`define HOLA_OFF_STATUS    8'h20
`define HOLA_OFF_COMMAND   8'h24

`define HOLA_RST_OC_THR    11'h3E8
`define HOLA_RST_OC_HYST   11'h001
`define HOLA_RST_LB_TIME   14'h0000
`define HOLA_RST_LB_LEVEL  14'h0050
`define HOLA_RST_LB_BAND   14'h001E
`define HOLA_RST_ALM_TYPE  8'h00

`define HOLA_OC_FORCE_ON   11'h000
`define HOLA_OC_FORCE_OFF  11'h3E8
`define HOLA_OC_THR_MAX    11'h3E8
`define HOLA_HYST_MAX      11'h3E8
`define HOLA_LB_TIME_MAX   14'h270F
`define HOLA_LB_VAL_MAX    14'h270F
`define HOLA_ALM_TYPE_LB   8'h0C

`define HOLA_ST_OC_BIT     0
`define HOLA_ST_LB_BIT     1
`define HOLA_CMD_RST_ERR   0

`endif

// ===== hola_plant.sv
/* Far side model: current transformer and temperature sensor.
   Assumes the bench sets the load current and the process value. */
`timescale 1ns/1ps
module hola_plant (
  input  wire               clk,
  input  wire               heat_on,
  input  wire        [10:0] load,
  input  wire signed [15:0] pv_in,
  output reg         [10:0] current = 11'h000,
  output reg  signed [15:0] pv = 16'sh0000
);
  // Load current flows only while heating is on, as a real heater would.
  always @(posedge clk) begin
    current <= heat_on ? load : 11'h000;
    pv      <= pv_in;
  end
endmodule

// ===== hola_chk_asserts.sv
/* Port assertions for the alarm block.
   Assumes it is bound into hola_alarm. */
`timescale 1ns/1ps
module hola_chk (
  input wire        REF_CLK,
  input wire        RSTN,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [7:0]  PADDR,
  input wire [31:0] PWDATA,
  input wire        PSLVERR,
  input wire        SW_RESET,
  input wire        RUNNING,
  input wire        SP_RAMPING,
  input wire        AUTOTUNING,
  input wire        MANUAL_MODE,
  input wire        HEAT_ON,
  input wire        COOLING_OUTPUT,
  input wire        CURRENT_TRANSFORMER_INPUT,
  input wire        HEATER_OVERCURRENT_ALARM,
  input wire        LOOP_BREAK_ALARM
);
  wire wr = PSEL && PENABLE && PWRITE;
  wire oc = HEATER_OVERCURRENT_ALARM;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  cool_off_a: assert property (
    COOLING_OUTPUT |=> !oc) else $error("alarm on cooling output");
  ct_off_a: assert property (
    !CURRENT_TRANSFORMER_INPUT |=> !oc) else $error("alarm without current input");
  heat_off_hold_a: assert property (
    (!HEAT_ON && CURRENT_TRANSFORMER_INPUT && !COOLING_OUTPUT && !SW_RESET && !wr)[*2]
    |=> $stable(oc)) else $error("alarm moved while heating off");
  swr_clear_a: assert property (
    SW_RESET |=> !oc) else $error("software reset kept alarm");
  cmd_clear_a: assert property (
    wr && PADDR == 8'h24 && PWDATA[0] |=> !oc) else $error("reset error kept alarm");
  thr_off_a: assert property (
    wr && PADDR == 8'h00 && PWDATA[10:0] >= 11'h3E8 |=> !oc) else $error("force off failed");
  run_lock_a: assert property (
    wr && RUNNING && PADDR >= 8'h04 && PADDR <= 8'h14 && PADDR[1:0] == 2'h0 |-> PSLVERR)
    else $error("write accepted while running");
  stop_lb_a: assert property (
    !RUNNING |=> !LOOP_BREAK_ALARM) else $error("loop alarm while stopped");
  mode_lb_a: assert property (
    SP_RAMPING || AUTOTUNING || MANUAL_MODE |=> !LOOP_BREAK_ALARM)
    else $error("loop alarm while suppressed");
endmodule
bind hola_alarm hola_chk u_chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSLVERR(PSLVERR),
  .SW_RESET(SW_RESET), .RUNNING(RUNNING), .SP_RAMPING(SP_RAMPING), .AUTOTUNING(AUTOTUNING),
  .MANUAL_MODE(MANUAL_MODE), .HEAT_ON(HEAT_ON), .COOLING_OUTPUT(COOLING_OUTPUT),
  .CURRENT_TRANSFORMER_INPUT(CURRENT_TRANSFORMER_INPUT),
  .HEATER_OVERCURRENT_ALARM(HEATER_OVERCURRENT_ALARM), .LOOP_BREAK_ALARM(LOOP_BREAK_ALARM));

// ===== testbench.sv
/* Self-checking bench for the alarm block.
   Assumes short on-time and second counts set below. */
`timescale 1ns/1ps
module testbench;
  reg                clk, rstn, psel, penable, pwrite, swr, run, ramp, at, man, heat, cool, ct;
  reg         [7:0]  paddr;
  reg         [31:0] pwdata, r;
  reg         [10:0] load;
  reg         [1:0]  dp;
  reg  signed [15:0] sp, pv_in;
  reg                e;
  wire        [31:0] prdata;
  wire               pready, pslverr, oc, lb;
  wire        [10:0] cur;
  wire signed [15:0] pv;
  integer            fails, n_checks, cyc;
  hola_alarm #(.ON_MIN_CYCLES(20), .SEC_CYCLES(50)) i_dut (.REF_CLK(clk), .RSTN(rstn),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SW_RESET(swr), .RUNNING(run),
    .SP_RAMPING(ramp), .AUTOTUNING(at), .MANUAL_MODE(man), .HEAT_ON(heat),
    .COOLING_OUTPUT(cool), .CURRENT_TRANSFORMER_INPUT(ct), .HEATER_CURRENT(cur),
    .DECIMAL_POS(dp), .PROCESS_VALUE(pv), .SET_POINT(sp),
    .HEATER_OVERCURRENT_ALARM(oc), .LOOP_BREAK_ALARM(lb));
  hola_plant i_plant (.clk(clk), .heat_on(heat), .load(load), .pv_in(pv_in),
    .current(cur), .pv(pv));
  task stop_test;
    begin
      if (fails == 0 && n_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Polls an alarm for a bounded number of cycles, then compares it.
  task wait_for(input sel, input val, input integer lim);
    integer i;
    begin
      for (i = 0; i < lim && (sel ? lb : oc) !== val; i = i + 1) @(posedge clk);
      chk(sel ? lb : oc, val);
    end
  endtask
  task t_regs;
    begin
      xfer(0, 8'h00, 0); chk(r, 32'h000003E8);
      xfer(0, 8'h04, 0); chk(r, 32'h00000001);
      xfer(0, 8'h08, 0); chk(r, 32'h00000000);
      xfer(0, 8'h0C, 0); chk(r, 32'h00000000);
      xfer(0, 8'h10, 0); chk(r, 32'h00000050);
      xfer(0, 8'h14, 0); chk(r, 32'h0000001E);
      xfer(0, 8'h30, 0); chk(e, 1);
    end
  endtask
  task t_oc;
    begin
      xfer(1, 8'h00, 32'h00000032);
      load <= 11'h03C; heat <= 1'b1;
      repeat (10) @(posedge clk);
      heat <= 1'b0;
      repeat (3) @(posedge clk);
      wait_for(0, 0, 0);
      heat <= 1'b1;
      wait_for(0, 1, 40);
      xfer(0, 8'h1C, 0); chk(r, 32'h0000003C);
      xfer(0, 8'h20, 0); chk(r, 32'h00000001);
      load <= 11'h031;
      repeat (5) @(posedge clk);
      wait_for(0, 1, 0);
      load <= 11'h030;
      wait_for(0, 0, 5);
      xfer(1, 8'h04, 32'h00000014); xfer(0, 8'h04, 0); chk(r, 32'h00000014);
      load <= 11'h03C; wait_for(0, 1, 5);
      load <= 11'h02F; wait_for(0, 0, 5);
      swr <= 1'b1;
      @(posedge clk) swr <= 1'b0;
      load <= 11'h03C; wait_for(0, 1, 5);
      load <= 11'h02F;
      repeat (5) @(posedge clk);
      wait_for(0, 1, 0);
    end
  endtask
  task t_latch;
    begin
      run <= 1'b1; xfer(1, 8'h08, 1); chk(e, 1);
      run <= 1'b0; xfer(1, 8'h08, 1); chk(e, 0);
      load <= 11'h03C; wait_for(0, 1, 40);
      load <= 11'h000;
      repeat (5) @(posedge clk);
      wait_for(0, 1, 0);
      xfer(1, 8'h24, 1); wait_for(0, 0, 2);
      load <= 11'h03C; wait_for(0, 1, 5);
      xfer(1, 8'h00, 32'h000003E8);
      repeat (5) @(posedge clk);
      wait_for(0, 0, 0);
      xfer(1, 8'h00, 32'h00000032); wait_for(0, 1, 5);
      swr <= 1'b1;
      @(posedge clk) swr <= 1'b0;
      cool <= 1'b1; wait_for(0, 0, 3);
      cool <= 1'b0; ct <= 1'b0; wait_for(0, 0, 3);
      ct <= 1'b1; heat <= 1'b0;
    end
  endtask
  task t_lb;
    begin
      xfer(1, 8'h18, 32'h0000000C); xfer(1, 8'h0C, 1);
      sp <= 16'sh03E8; pv_in <= 16'sh0320; run <= 1'b1;
      wait_for(1, 1, 120);
      pv_in <= 16'sh0352; wait_for(1, 0, 5);
      wait_for(1, 1, 200);
      pv_in <= 16'sh03DE; wait_for(1, 0, 5);
      dp <= 2'h0; sp <= 16'sh0064; pv_in <= 16'sh005A; wait_for(1, 1, 200);
      {ramp, at, man} <= 3'b111; wait_for(1, 0, 3);
      {ramp, at, man} <= 3'b000; run <= 1'b0;
      xfer(1, 8'h0C, 0); run <= 1'b1;
      repeat (150) @(posedge clk);
      wait_for(1, 0, 0);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      stop_test;
    end
  end
  initial begin
    {rstn, psel, penable, pwrite, swr, run, ramp, at, man, heat, cool} = 11'h000;
    ct = 1'b1; paddr = 8'h00; pwdata = 32'h00000000; load = 11'h000; dp = 2'h1;
    sp = 16'sh0000; pv_in = 16'sh0000; fails = 0; n_checks = 0; cyc = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_oc;
    t_latch;
    t_lb;
    stop_test;
  end
endmodule
